// >>> design/array_clock_generator.sv
// Array clock generator, control sequencer, microcode store enables and serial diagnostic chain
//
// Contract
// - Memory write strobe low on last tick
// - Host access halts, then grant two ticks later
// - Host write strobe one tick after grant
// - Host cycle ack tick after write strobe
// - Go withdrawn in low: finish, halt with clock
// - Still no go next tick: drop memory enable
// - Go withdrawn while high: halt at once
// - Reset request is system reset or flag
// - Run reset: three two-tick clocks, reset low
// - Clocks clear reset flag; then resume run
// - Reset without go enters reset/halt mode
// - System reset clears run, step and reset flags
// - Go in reset/halt starts reset sequence
// - Halted reset plus step: three clocks, halt
// - Chip enable: memory enable or host access
// - Output enable: memory enable or host read
// - Write enable follows host write strobe
// - Pipe clocks follow clock plus host pulses
// - One serial chain of 288 bits, input to output
// - Host moves chain, parallel and microcode words
// - Store 8K by 88; address mux
// - Period select sets next low time
// - Go is run or step without access
// - Enable two ticks before, one after edge
// - Each sequencer clock clears step flag
`timescale 1ns/10ps
`include "array_clock_defines.svh"

module array_clock_generator #(
   parameter int CHAIN_W = 288,
   parameter int UWORD_W = 88,
   parameter int UADDR_W = 13
) (
   input  wire logic                          clk_i,
   input  wire logic                          rst_i,
   input  wire array_clock_pkg::wb_req_s      wb_req_i,
   output      array_clock_pkg::wb_rsp_s      wb_rsp_o,
   input  wire logic                          sys_reset_n_i,
   input  wire logic                          host_access_request_n_i,
   input  wire logic                          host_write_i,
   input  wire logic                          host_ucode_read_n_i,
   input  wire logic                          host_ucode_write_n_i,
   input  wire logic [UADDR_W-1:0]            host_data_i,
   input  wire logic [UADDR_W-1:0]            seq_addr_i,
   input  wire logic                          mem_write_req_n_i,
   input  wire logic                          period_select_high_i,
   input  wire logic                          period_select_low_i,
   input  wire logic [UWORD_W-1:0]            ucode_data_i,
   input  wire logic [CHAIN_W-1:0]            pipe_capture_i,
   input  wire logic                          serial_chain_in_i,
   output      logic                          array_clk_o,
   output      logic                          seq_clk_o,
   output      logic                          data_write_strobe_n_o,
   output      logic                          mem_enable_n_o,
   output      logic                          halt_o,
   output      logic                          seq_reset_n_o,
   output      logic                          host_mem_grant_n_o,
   output      logic                          host_write_request_n_o,
   output      logic                          host_cycle_ack_n_o,
   output      logic                          ucode_chip_enable_n_o,
   output      logic                          ucode_output_enable_n_o,
   output      logic                          ucode_write_enable_n_o,
   output      logic [UADDR_W-1:0]            ucode_addr_o,
   output      logic [UWORD_W-1:0]            ucode_write_data_o,
   output      logic                          pipe_parallel_clock_a_o,
   output      logic                          pipe_parallel_clock_b_o,
   output      logic [CHAIN_W-1:0]            pipe_word_o,
   output      logic                          serial_chain_out_o
);

   array_clock_pkg::clk_state_e  state;
   array_clock_pkg::clk_state_e  next_state;
   array_clock_pkg::host_phase_e host_phase;
   array_clock_pkg::host_phase_e next_host_phase;
   logic [3:0]         low_cnt;
   logic [3:0]         next_low_cnt;
   logic [3:0]         sel_low;
   logic [1:0]         rst_cnt;
   logic [1:0]         next_rst_cnt;
   logic [2:0]         sys_sync;
   logic               sys_reset;
   logic               run_flag;
   logic               single_step_flag;
   logic               host_reset_flag;
   logic               pclk_pulse;
   logic               shift_pulse;
   logic               capture_pulse;
   logic               transfer_pulse;
   logic               go;
   logic               reset_request;
   logic               halted;
   logic               next_clk;
   logic               next_halt;
   logic               next_mem_en;
   logic               next_seq_rst;
   logic               next_dstrobe;
   logic               seq_rise;
   logic               pipe_clk;
   logic               pipe_clk_q;
   logic               wb_hit;
   logic               wb_write;
   logic [CHAIN_W-1:0] chain;

   // System reset comes off the backplane: three stages, a change counts once two agree
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sys_sync  <= 3'h7;
         sys_reset <= 1'b0;
      end else begin
         sys_sync <= {sys_sync[1:0], sys_reset_n_i};
         if (sys_sync[1] == sys_sync[2]) begin
            sys_reset <= ~sys_sync[2];
         end
      end
   end

   assign go            = (run_flag | single_step_flag) & host_access_request_n_i;
   assign reset_request = sys_reset | host_reset_flag;
   assign halted        = (state == array_clock_pkg::ST_HALT) || (state == array_clock_pkg::ST_RST_HALT);
   assign wb_hit        = wb_req_i.cyc & wb_req_i.stb & ~wb_rsp_o.ack;
   assign wb_write      = wb_hit & wb_req_i.we & wb_req_i.sel[0] & (wb_req_i.adr == `ACG_REG_CMD);

   always_comb begin
      unique case ({period_select_high_i, period_select_low_i})
         2'h0: sel_low = `ACG_LOW_SEL00;
         2'h1: sel_low = `ACG_LOW_SEL01;
         2'h2: sel_low = `ACG_LOW_SEL10;
         2'h3: sel_low = `ACG_LOW_SEL11;
      endcase
   end

   // Clock state machine; every strobe is computed from the next state so all change on one edge
   always_comb begin
      next_state   = state;
      next_low_cnt = low_cnt;
      next_rst_cnt = rst_cnt;
      unique case (state)
         array_clock_pkg::ST_HALT: begin
            if (go && reset_request) begin
               next_state   = array_clock_pkg::ST_RST_LOW;
               next_rst_cnt = `ACG_RESET_CYCLES;
            end else if (reset_request) begin
               next_state = array_clock_pkg::ST_RST_HALT;
            end else if (go) begin
               next_state   = array_clock_pkg::ST_LOW;
               next_low_cnt = sel_low;
            end
         end
         array_clock_pkg::ST_LOW: begin
            if (low_cnt == 4'h1) begin
               next_state = array_clock_pkg::ST_HIGH;
            end else begin
               next_low_cnt = low_cnt - 4'h1;
            end
         end
         array_clock_pkg::ST_HIGH: begin
            if (!go) begin
               next_state = reset_request ? array_clock_pkg::ST_RST_HALT
                                          : array_clock_pkg::ST_HALT;
            end else if (reset_request) begin
               next_state = array_clock_pkg::ST_RST_ENTER;
            end else begin
               next_state   = array_clock_pkg::ST_LOW;
               next_low_cnt = sel_low;
            end
         end
         array_clock_pkg::ST_RST_ENTER: begin
            next_state   = array_clock_pkg::ST_RST_LOW;
            next_rst_cnt = `ACG_RESET_CYCLES;
         end
         array_clock_pkg::ST_RST_LOW: begin
            next_state = array_clock_pkg::ST_RST_HIGH;
         end
         array_clock_pkg::ST_RST_HIGH: begin
            if (rst_cnt != `ACG_RESET_LAST) begin
               next_state   = array_clock_pkg::ST_RST_LOW;
               next_rst_cnt = rst_cnt - 2'h1;
            end else if (reset_request) begin
               // A held system reset keeps the sequencer clocked in reset
               next_state   = array_clock_pkg::ST_RST_LOW;
               next_rst_cnt = `ACG_RESET_CYCLES;
            end else if (go) begin
               next_state   = array_clock_pkg::ST_LOW;
               next_low_cnt = sel_low;
            end else begin
               next_state = array_clock_pkg::ST_HALT;
            end
         end
         array_clock_pkg::ST_RST_HALT: begin
            if (go) begin
               next_state   = array_clock_pkg::ST_RST_LOW;
               next_rst_cnt = `ACG_RESET_CYCLES;
            end
         end
      endcase
   end

   always_comb begin
      next_clk     = (next_state != array_clock_pkg::ST_LOW) && (next_state != array_clock_pkg::ST_RST_LOW);
      next_halt    = (next_state == array_clock_pkg::ST_HALT) || (next_state == array_clock_pkg::ST_RST_HALT)
                     || ((next_state == array_clock_pkg::ST_HIGH) && !go);
      next_mem_en  = ((next_state == array_clock_pkg::ST_LOW) && (next_low_cnt <= `ACG_ENABLE_LEAD))
                     || (next_state == array_clock_pkg::ST_HIGH)
                     || (next_state == array_clock_pkg::ST_RST_ENTER)
                     || (next_state == array_clock_pkg::ST_RST_LOW)
                     || (next_state == array_clock_pkg::ST_RST_HIGH);
      next_seq_rst = (next_state == array_clock_pkg::ST_RST_ENTER) || (next_state == array_clock_pkg::ST_RST_LOW)
                     || (next_state == array_clock_pkg::ST_RST_HIGH) || (next_state == array_clock_pkg::ST_RST_HALT);
      next_dstrobe = ((next_state == array_clock_pkg::ST_LOW) && (next_low_cnt == 4'h1) && !mem_write_req_n_i)
                     || ((next_host_phase == array_clock_pkg::HP_STROBE) && host_write_i);
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state   <= array_clock_pkg::ST_HALT;
         low_cnt <= `ACG_LOW_SEL00;
         rst_cnt <= `ACG_RESET_CYCLES;
      end else begin
         state   <= next_state;
         low_cnt <= next_low_cnt;
         rst_cnt <= next_rst_cnt;
      end
   end

   // Registered strobes; the array clock and its derivatives rise on the same oscillator edge
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         array_clk_o           <= 1'b1;
         seq_clk_o             <= 1'b1;
         pipe_clk_q            <= 1'b1;
         halt_o                <= 1'b1;
         mem_enable_n_o        <= 1'b1;
         seq_reset_n_o         <= 1'b1;
         data_write_strobe_n_o <= 1'b1;
      end else begin
         array_clk_o           <= next_clk;
         seq_clk_o             <= next_clk;
         pipe_clk_q            <= next_clk & ~pclk_pulse;
         halt_o                <= next_halt;
         mem_enable_n_o        <= ~next_mem_en;
         seq_reset_n_o         <= ~next_seq_rst;
         data_write_strobe_n_o <= ~next_dstrobe;
      end
   end

   assign seq_rise                = next_clk & ~seq_clk_o;
   assign pipe_clk                = next_clk & ~pclk_pulse;
   assign pipe_parallel_clock_a_o = pipe_clk_q;
   assign pipe_parallel_clock_b_o = pipe_clk_q;

   // Host data memory access handshake, started only once the clock stands halted
   always_comb begin
      next_host_phase = host_phase;
      if (host_access_request_n_i) begin
         next_host_phase = array_clock_pkg::HP_IDLE;
      end else begin
         unique case (host_phase)
            array_clock_pkg::HP_IDLE:   if (halted) next_host_phase = array_clock_pkg::HP_WAIT;
            array_clock_pkg::HP_WAIT:   next_host_phase = array_clock_pkg::HP_GRANT;
            array_clock_pkg::HP_GRANT:  next_host_phase = array_clock_pkg::HP_STROBE;
            array_clock_pkg::HP_STROBE: next_host_phase = array_clock_pkg::HP_ACK;
            array_clock_pkg::HP_ACK:    next_host_phase = array_clock_pkg::HP_ACK;
         endcase
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         host_phase             <= array_clock_pkg::HP_IDLE;
         host_mem_grant_n_o     <= 1'b1;
         host_write_request_n_o <= 1'b1;
         host_cycle_ack_n_o     <= 1'b1;
      end else begin
         host_phase             <= next_host_phase;
         host_mem_grant_n_o     <= (next_host_phase == array_clock_pkg::HP_IDLE)
                                   || (next_host_phase == array_clock_pkg::HP_WAIT);
         host_write_request_n_o <= ~host_write_i || (next_host_phase == array_clock_pkg::HP_IDLE)
                                   || (next_host_phase == array_clock_pkg::HP_WAIT);
         host_cycle_ack_n_o     <= (next_host_phase != array_clock_pkg::HP_ACK);
      end
   end

   // Command flags; a sequencer clock clear loses to a set written in the same cycle, a system reset wins
   always_ff @(posedge clk_i) begin
      if (rst_i || sys_reset) begin
         run_flag         <= 1'b0;
         single_step_flag <= 1'b0;
         host_reset_flag  <= 1'b0;
      end else if (wb_write) begin
         run_flag         <= wb_req_i.dat[`ACG_CMD_RUN];
         single_step_flag <= wb_req_i.dat[`ACG_CMD_STEP] | (single_step_flag & ~seq_rise);
         host_reset_flag  <= wb_req_i.dat[`ACG_CMD_HOST_RESET_FLAG] | (host_reset_flag & ~seq_rise);
      end else if (seq_rise) begin
         single_step_flag <= 1'b0;
         host_reset_flag  <= 1'b0;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pclk_pulse     <= 1'b0;
         shift_pulse    <= 1'b0;
         capture_pulse  <= 1'b0;
         transfer_pulse <= 1'b0;
      end else begin
         pclk_pulse     <= wb_write & wb_req_i.dat[`ACG_CMD_PCLK];
         shift_pulse    <= wb_write & wb_req_i.dat[`ACG_CMD_SHIFT];
         capture_pulse  <= wb_write & wb_req_i.dat[`ACG_CMD_CAPTURE];
         transfer_pulse <= wb_write & wb_req_i.dat[`ACG_CMD_TRANSFER];
      end
   end

   // Serial diagnostic chain and the parallel pipeline word behind it
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         chain <= '0;
      end else if (capture_pulse) begin
         chain <= pipe_capture_i;
      end else if (shift_pulse) begin
         chain <= {chain[CHAIN_W-2:0], serial_chain_in_i};
      end
   end

   // A pipe clock edge takes the store output, so a host read lands in the low word
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pipe_word_o <= '0;
      end else if (transfer_pulse) begin
         pipe_word_o <= chain;
      end else if (pipe_clk & ~pipe_clk_q) begin
         pipe_word_o[UWORD_W-1:0] <= ucode_data_i;
      end
   end

   assign serial_chain_out_o      = chain[CHAIN_W-1];
   assign ucode_write_data_o      = chain[UWORD_W-1:0];
   assign ucode_chip_enable_n_o   = mem_enable_n_o & host_ucode_read_n_i & host_ucode_write_n_i;
   assign ucode_output_enable_n_o = mem_enable_n_o & host_ucode_read_n_i;
   assign ucode_write_enable_n_o  = host_ucode_write_n_i;
   assign ucode_addr_o            = (host_ucode_read_n_i & host_ucode_write_n_i) ? seq_addr_i : host_data_i;

   // Classic Wishbone slave: one wait state, unmapped offsets answer zero
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_rsp_o <= '0;
      end else begin
         wb_rsp_o.ack <= wb_hit;
         wb_rsp_o.dat <= 32'h0;
         if (wb_hit && !wb_req_i.we) begin
            unique case (wb_req_i.adr)
               `ACG_REG_CMD: begin
                  wb_rsp_o.dat[`ACG_CMD_RUN]    <= run_flag;
                  wb_rsp_o.dat[`ACG_CMD_STEP]   <= single_step_flag;
                  wb_rsp_o.dat[`ACG_CMD_HOST_RESET_FLAG] <= host_reset_flag;
               end
               `ACG_REG_STATUS: begin
                  wb_rsp_o.dat[`ACG_ST_HALT]       <= halt_o;
                  wb_rsp_o.dat[`ACG_ST_SEQ_RESET]  <= ~seq_reset_n_o;
                  wb_rsp_o.dat[`ACG_ST_MEM_ENABLE] <= ~mem_enable_n_o;
                  wb_rsp_o.dat[`ACG_ST_GRANT]      <= ~host_mem_grant_n_o;
                  wb_rsp_o.dat[`ACG_ST_RESET_REQ]  <= reset_request;
                  wb_rsp_o.dat[`ACG_ST_CHAIN_OUT]  <= chain[CHAIN_W-1];
               end
               default: wb_rsp_o.dat <= 32'h0;
            endcase
         end
      end
   end

endmodule // array_clock_generator

// >>> design/array_clock_defines.svh
// Register offsets, field positions and timing counts of the array clock generator
`ifndef ARRAY_CLOCK_DEFINES_SVH
`define ARRAY_CLOCK_DEFINES_SVH

// Register byte offsets
`define ACG_REG_CMD          4'h0
`define ACG_REG_STATUS       4'h4

// Command register fields
`define ACG_CMD_RUN          0
`define ACG_CMD_STEP         1
`define ACG_CMD_HOST_RESET_FLAG       2
`define ACG_CMD_PCLK         3
`define ACG_CMD_SHIFT        4
`define ACG_CMD_CAPTURE      5
`define ACG_CMD_TRANSFER     6

// Status register fields
`define ACG_ST_HALT          0
`define ACG_ST_SEQ_RESET     1
`define ACG_ST_MEM_ENABLE    2
`define ACG_ST_GRANT         3
`define ACG_ST_RESET_REQ     4
`define ACG_ST_CHAIN_OUT     5

// Low time of a run period in oscillator ticks; the high time is one tick
`define ACG_LOW_SEL00        4'h1
`define ACG_LOW_SEL01        4'h3
`define ACG_LOW_SEL10        4'h7
`define ACG_LOW_SEL11        4'hA

// Memory enable leads the rising edge by this many low ticks
`define ACG_ENABLE_LEAD      4'h2
// Sequencer clock periods produced by a reset sequence
`define ACG_RESET_CYCLES     2'h3
`define ACG_RESET_LAST       2'h1

`endif

// >>> design/array_clock_pkg.sv
// Types shared by the array clock generator and its bench
package array_clock_pkg;

   typedef enum logic [2:0] {
      ST_HALT,
      ST_LOW,
      ST_HIGH,
      ST_RST_ENTER,
      ST_RST_LOW,
      ST_RST_HIGH,
      ST_RST_HALT
   } clk_state_e;

   typedef enum logic [2:0] {
      HP_IDLE,
      HP_WAIT,
      HP_GRANT,
      HP_STROBE,
      HP_ACK
   } host_phase_e;

   typedef struct packed {
      logic        cyc;
      logic        stb;
      logic        we;
      logic [3:0]  adr;
      logic [3:0]  sel;
      logic [31:0] dat;
   } wb_req_s;

   typedef struct packed {
      logic [31:0] dat;
      logic        ack;
   } wb_rsp_s;

endpackage

// >>> testbench/acg_asserts.sv
// Port checker for the array clock generator
`timescale 1ns/10ps
module acg_asserts (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic host_write_i,
   input wire logic host_ucode_read_n_i,
   input wire logic host_ucode_write_n_i,
   input wire logic array_clk_o,
   input wire logic data_write_strobe_n_o,
   input wire logic mem_enable_n_o,
   input wire logic halt_o,
   input wire logic host_mem_grant_n_o,
   input wire logic host_cycle_ack_n_o,
   input wire logic ucode_chip_enable_n_o,
   input wire logic ucode_output_enable_n_o,
   input wire logic ucode_write_enable_n_o
);
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);
   // Host strobes are excluded here, they run while the clock is parked
   a_strobe_at_end: assert property (!data_write_strobe_n_o && host_mem_grant_n_o |=> $rose(array_clk_o))
      else $error("write strobe not followed by clock rise");
   a_host_strobe: assert property ($fell(host_mem_grant_n_o) && host_write_i |=>
      !data_write_strobe_n_o ##1 data_write_strobe_n_o) else $error("host write strobe misplaced");
   a_ack_after_grant: assert property ($fell(host_mem_grant_n_o) |-> ##2 $fell(host_cycle_ack_n_o))
      else $error("host cycle ack not two ticks after grant");
   a_grant_halted: assert property (!host_mem_grant_n_o |-> halt_o) else $error("grant while running");
   a_halt_with_clk: assert property ($rose(halt_o) |-> array_clk_o) else $error("halt raised with clock low");
   a_enable_lead: assert property ($rose(array_clk_o) |-> !mem_enable_n_o && !$past(mem_enable_n_o))
      else $error("memory enable not around clock rise");
   a_chip_enable: assert property (ucode_chip_enable_n_o ==
      (mem_enable_n_o && host_ucode_read_n_i && host_ucode_write_n_i)) else $error("chip enable wrong");
   a_output_enable: assert property (ucode_output_enable_n_o ==
      (mem_enable_n_o && host_ucode_read_n_i)) else $error("output enable wrong");
   a_write_enable: assert property (ucode_write_enable_n_o == host_ucode_write_n_i)
      else $error("write enable wrong");
endmodule // acg_asserts
bind array_clock_generator acg_asserts asserts (.clk_i, .rst_i, .host_write_i, .host_ucode_read_n_i,
   .host_ucode_write_n_i, .array_clk_o, .data_write_strobe_n_o, .mem_enable_n_o, .halt_o, .host_mem_grant_n_o,
   .host_cycle_ack_n_o, .ucode_chip_enable_n_o, .ucode_output_enable_n_o, .ucode_write_enable_n_o);

// >>> testbench/host_model.sv
// Host interface stand-in that parks the clock before each data memory access
`timescale 1ns/10ps
module host_model (
   input  wire logic clk_i,
   input  wire logic go_i,
   input  wire logic write_i,
   input  wire logic halt_i,
   input  wire logic ack_n_i,
   output logic      req_n_o = 1'b1,
   output logic      wr_o = 1'b0,
   output logic      done_o = 1'b0
);
   always @(posedge clk_i) begin
      done_o <= 1'b0;
      if (go_i && req_n_o) begin
         req_n_o <= 1'b0;
         wr_o <= write_i;
      end else if (!req_n_o && halt_i && !ack_n_i) begin
         // Proceed only once halted and answered
         req_n_o <= 1'b1;
         wr_o <= 1'b0;
         done_o <= 1'b1;
      end
   end
endmodule // host_model

// >>> testbench/tb.sv
// Self-checking bench for the array clock generator
`timescale 1ns/10ps
module tb;
   logic clk_i = 1'b0, rst_i = 1'b1, sys_reset_n_i = 1'b1, hgo = 1'b0, hwr = 1'b0, hdone;
   logic host_ucode_read_n_i = 1'b1, host_ucode_write_n_i = 1'b1, mem_write_req_n_i = 1'b1;
   logic period_select_high_i = 1'b0, period_select_low_i = 1'b0, serial_chain_in_i = 1'b0;
   logic host_access_request_n_i, host_write_i, array_clk_o, seq_clk_o, halt_o, seq_reset_n_o;
   logic mem_enable_n_o, host_cycle_ack_n_o, serial_chain_out_o, pipe_parallel_clock_a_o, pipe_parallel_clock_b_o;
   logic [12:0]  ucode_addr_o;
   logic [87:0]  ucode_write_data_o;
   logic [287:0] pipe_word_o;
   logic [12:0]  host_data_i = '0, seq_addr_i = '0;
   logic [87:0]  ucode_data_i = '0;
   logic [287:0] pipe_capture_i = '0;
   logic [31:0]  rd;
   array_clock_pkg::wb_req_s wb_req_i = '0;
   array_clock_pkg::wb_rsp_s wb_rsp_o;
   int n_fail = 0, n_compared = 0, i, t;
   array_clock_generator dut (.clk_i, .rst_i, .wb_req_i, .wb_rsp_o, .sys_reset_n_i, .host_access_request_n_i,
      .host_write_i, .host_ucode_read_n_i, .host_ucode_write_n_i, .host_data_i, .seq_addr_i, .mem_write_req_n_i,
      .period_select_high_i, .period_select_low_i, .ucode_data_i, .pipe_capture_i, .serial_chain_in_i,
      .array_clk_o, .seq_clk_o, .data_write_strobe_n_o(), .mem_enable_n_o, .halt_o, .seq_reset_n_o,
      .host_mem_grant_n_o(), .host_write_request_n_o(), .host_cycle_ack_n_o, .ucode_chip_enable_n_o(),
      .ucode_output_enable_n_o(), .ucode_write_enable_n_o(), .ucode_addr_o, .ucode_write_data_o,
      .pipe_parallel_clock_a_o, .pipe_parallel_clock_b_o, .pipe_word_o, .serial_chain_out_o);
   host_model hm (.clk_i, .go_i(hgo), .write_i(hwr), .halt_i(halt_o), .ack_n_i(host_cycle_ack_n_o),
      .req_n_o(host_access_request_n_i), .wr_o(host_write_i), .done_o(hdone));
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         n_fail++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wb(input logic we, input logic [3:0] a, input logic [31:0] d);
      int k;
      k = 0;
      wb_req_i <= '{1'b1, 1'b1, we, a, 4'hF, d};
      do begin
         @(posedge clk_i);
         k++;
      end while (wb_rsp_o.ack !== 1'b1 && k < 50);
      if (k >= 50) n_fail++;
      rd = wb_rsp_o.dat;
      wb_req_i <= '0;
      @(posedge clk_i);
   endtask
   // Ticks from one sampled clock rise to the next
   task automatic rise(output int n);
      n = 0;
      while (array_clk_o !== 1'b0 && n < 40) begin
         @(posedge clk_i);
         n++;
      end
      while (array_clk_o !== 1'b1 && n < 40) begin
         @(posedge clk_i);
         n++;
      end
   endtask
   task automatic cnt(input logic rst_only, output int n);
      logic p;
      n = 0;
      // A reset clock may already be low when the write returns, so start from the present level
      p = seq_clk_o;
      repeat (40) begin
         @(posedge clk_i);
         n += int'(seq_clk_o === 1'b1 && !p && (!rst_only || seq_reset_n_o === 1'b0));
         p = seq_clk_o;
      end
   endtask
   task automatic hold_halt();
      t = 0;
      while (halt_o !== 1'b1 && t < 30) begin
         @(posedge clk_i);
         t++;
      end
   endtask
   function automatic int per(input logic [1:0] s);
      return s == 2'b00 ? 2 : s == 2'b01 ? 4 : s == 2'b10 ? 8 : 11;
   endfunction
   task automatic summarize();
      $display("compared %0d failed %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   initial forever #50 clk_i = ~clk_i;
   initial begin
      #300000;
      n_fail++;
      summarize();
   end
   initial begin
      void'($urandom(92247));
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      chk({halt_o, array_clk_o, mem_enable_n_o, seq_reset_n_o}, 32'hF);
      wb(1'b0, 4'h8, 32'h0);
      chk(rd, 32'h0);
      for (i = 0; i < 4; i++) begin
         {period_select_high_i, period_select_low_i} <= 2'(i);
         mem_write_req_n_i <= 1'($urandom);
         host_ucode_read_n_i <= 1'($urandom);
         host_ucode_write_n_i <= 1'($urandom);
         host_data_i <= 13'($urandom);
         seq_addr_i <= 13'($urandom);
         ucode_data_i <= 88'({3{$urandom}});
         pipe_capture_i <= {9{$urandom}};
         serial_chain_in_i <= 1'($urandom);
         wb(1'b1, 4'h0, 32'h1);
         chk(ucode_addr_o, (host_ucode_read_n_i & host_ucode_write_n_i) ? seq_addr_i : host_data_i);
         rise(t);
         rise(t);
         rise(t);
         chk(t, per(2'(i)));
      end
      host_ucode_read_n_i <= 1'b1;
      host_ucode_write_n_i <= 1'b1;
      // Accesses land while running, so each must first park the clock
      for (i = 0; i < 2; i++) begin
         hgo <= 1'b1;
         hwr <= 1'(i == 0);
         @(posedge clk_i);
         hgo <= 1'b0;
         t = 0;
         while (hdone !== 1'b1 && t < 60) begin
            @(posedge clk_i);
            t++;
         end
         chk(hdone, 1'b1);
      end
      wb(1'b1, 4'h0, 32'h0);
      hold_halt();
      chk({halt_o, array_clk_o}, 32'h3);
      repeat (2) @(posedge clk_i);
      chk(mem_enable_n_o, 1'b1);
      wb(1'b1, 4'h0, 32'h2);
      cnt(1'b0, t);
      chk(t, 32'h1);
      wb(1'b1, 4'h0, 32'h6);
      cnt(1'b1, t);
      chk({halt_o, 31'(t)}, 32'h80000003);
      wb(1'b0, 4'h0, 32'h0);
      chk(rd[2:0], 3'h0);
      wb(1'b1, 4'h0, 32'h20);
      chk({serial_chain_out_o, ucode_write_data_o[30:0]}, {pipe_capture_i[287], pipe_capture_i[30:0]});
      wb(1'b1, 4'h0, 32'h40);
      chk(pipe_word_o[287:256], pipe_capture_i[287:256]);
      wb(1'b1, 4'h0, 32'h10);
      chk(serial_chain_out_o, pipe_capture_i[286]);
      wb(1'b1, 4'h0, 32'h8);
      chk({pipe_parallel_clock_a_o, pipe_parallel_clock_b_o}, 32'h0);
      @(posedge clk_i);
      chk(pipe_word_o[31:0], ucode_data_i[31:0]);
      // Host reset flag parks the array first, so the system reset has a flag to clear
      wb(1'b1, 4'h0, 32'h4);
      sys_reset_n_i <= 1'b0;
      repeat (12) @(posedge clk_i);
      chk({halt_o, seq_reset_n_o, mem_enable_n_o}, 3'b101);
      sys_reset_n_i <= 1'b1;
      repeat (12) @(posedge clk_i);
      wb(1'b0, 4'h0, 32'h0);
      chk(rd[2:0], 3'h0);
      wb(1'b1, 4'h0, 32'h1);
      cnt(1'b1, t);
      chk({halt_o, 31'(t)}, 32'h3);
      summarize();
   end
endmodule // tb
